// ### ssic_pkg.sv
// ssic_pkg: constants for the standby (stop/idle) controller
// assumes: single 25 MHz system clock, no register bus
package ssic_pkg;
	localparam int unsigned SSIC_CLK_HZ      = 25000000;
	localparam int unsigned SSIC_OSC_STAB_US = 1000;
	localparam int unsigned SSIC_OSC_STAB_CYC =
		(SSIC_OSC_STAB_US * (SSIC_CLK_HZ / 1000000));
	localparam int unsigned SSIC_NUM_EXT_IRQ = 7;
	localparam int unsigned SSIC_NUM_CSI     = 3;
	localparam logic [1:0]  SSIC_ADC_OFF     = 2'h0;
	typedef enum logic [1:0]
	{
		SSIC_NORMAL = 2'b00,
		SSIC_IDLE   = 2'b01,
		SSIC_STOP   = 2'b10,
		SSIC_STAB   = 2'b11
	} ssic_state_t;
endpackage

// ### ssic_wake_detect.sv
// ssic_wake_detect: combinational wake request qualification
// assumes: inputs already synchronised; needs no main clock to evaluate
`timescale 1ns/1ps
`default_nettype none
module ssic_wake_detect
	import ssic_pkg::*;
#(
	parameter int unsigned N_EXT = SSIC_NUM_EXT_IRQ
)
(
	input  wire logic             i_nmi_pin,        // nmi pin level
	input  wire logic [N_EXT-1:0] i_ext_irq,        // external irq pins
	input  wire logic [N_EXT-1:0] i_ext_irq_en,     // per-pin unmask
	input  wire logic             i_periph_irq,     // unmasked periph irq
	input  wire logic             i_wdt_irq,        // watchdog overflow irq
	input  wire logic             i_wdt_rst,        // watchdog reset request
	input  wire logic             i_on_subclock,    // cpu runs on subclock
	input  wire logic             i_pin_nmi_mask,   // mask for nmi pin
	input  wire logic             i_wdt_nmi_mask,   // mask for watchdog nmi
	input  wire logic             i_maskable_mask,  // mask for maskable irqs
	output logic                  o_wake            // qualified wake request
);
	logic nmi_wake;
	logic mask_wake;
	always_comb
	begin
		// pure gates so release works with the main oscillator halted
		nmi_wake = (i_nmi_pin & ~i_pin_nmi_mask)
			| (i_wdt_irq & i_on_subclock & ~i_wdt_nmi_mask);
		mask_wake = ~i_maskable_mask
			& ((|(i_ext_irq & i_ext_irq_en)) | i_periph_irq);
		o_wake = nmi_wake | mask_wake | (i_wdt_rst & i_on_subclock);
	end
endmodule
`default_nettype wire

// ### ssic_top.sv
// ssic_top: standby controller, stop/idle entry, gating and wake-up
// assumes: cpu issues the stop request strobe; ram and ports sit outside
// Notes on behaviour
// - stop entered from normal only when mode select and stop request are 1
// - in stop the main oscillator halts, subclock oscillator keeps running
// - in stop cpu and peripheral clocks are gated off
// - internal ram contents are kept throughout stop
// - subclock peripherals keep running in stop; externally clocked serials stop
// - wake on nmi, unmasked ext/periph irq, reset, watchdog on subclock
// - after stop release wait oscillator stabilisation, then normal
// - idle stops watchdog one; watchdog two runs only on subclock count
// - idle keeps clocked serial units running on external serial clock
// - idle keeps first uart on external baud clock; other serials stop
// - idle keeps dac output but freezes its value register
// - idle keeps real-time output on timer8 match if timer enabled
// - idle holds every port pin state
// - idle keeps cpu registers, status, ram and all internal data
// - masked wake requests are ignored and do not release standby
`timescale 1ns/1ps
`default_nettype none
module ssic_top
	import ssic_pkg::*;
#(
	parameter int unsigned STAB_CYC = SSIC_OSC_STAB_CYC,
	parameter int unsigned N_EXT    = SSIC_NUM_EXT_IRQ,
	parameter int unsigned N_CSI    = SSIC_NUM_CSI
)
(
	input  wire logic             i_sys_clk,              // 25 MHz clock
	input  wire logic             i_rst_b,                // async reset, low
	input  wire logic             i_power_save_mode_select, // 1 = stop mode
	input  wire logic             i_stop_request_bit,     // stop store pulse
	input  wire logic             i_idle_request,         // idle store pulse
	input  wire logic             i_pin_nonmask_irq_mask, // nmi pin mask
	input  wire logic             i_wdt_nonmask_irq_mask, // wdt nmi mask
	input  wire logic             i_maskable_irq_mask,    // maskable mask
	input  wire logic             i_nmi_pin,              // nmi pin
	input  wire logic [N_EXT-1:0] i_external_irq_pins,    // ext irq pins
	input  wire logic [N_EXT-1:0] i_ext_irq_en,           // ext irq unmask
	input  wire logic             i_periph_irq,           // periph irq
	input  wire logic             i_watchdog_overflow_irq, // wdt2 irq
	input  wire logic             i_watchdog_reset_request, // wdt2 reset
	input  wire logic             i_on_subclock,          // cpu on subclock
	input  wire logic             i_wdt2_subclk_sel,      // wdt2 on subclock
	input  wire logic [N_CSI-1:0] i_csi_ext_clk_sel,      // csi ext clk sel
	input  wire logic             i_uart0_ext_clk_sel,    // uart0 baud sel
	input  wire logic             i_rto_timer8_trig,      // rto on timer8
	input  wire logic             i_timer8_idle_en,       // timer8 idle run
	output logic                  o_main_osc_en,          // main oscillator
	output logic                  o_sub_osc_en,           // subclock osc
	output logic                  o_cpu_clk_en,           // cpu clock gate
	output logic                  o_periph_clk_en,        // periph clock gate
	output logic                  o_sub_periph_clk_en,    // subclock periphs
	output logic                  o_ram_hold,             // ram retention
	output logic                  o_port_hold,            // ports latch
	output logic                  o_data_write_block,     // dac/rto/cpu hold
	output logic                  o_wdt1_run,             // watchdog one
	output logic                  o_wdt2_run,             // watchdog two
	output logic [N_CSI-1:0]      o_csi_run,              // clocked serials
	output logic                  o_uart0_run,            // first uart
	output logic                  o_other_serial_run,     // others
	output logic                  o_dac_out_en,           // dac drives out
	output logic                  o_rto_run,              // real-time output
	output logic [1:0]            o_state                 // standby state
);
	////////////////////////////////////////////////////////////////
	logic rst_m;
	logic rst_s;
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end

	// pin inputs pass two flops before use
	localparam int unsigned NSYNC = N_EXT + 3;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	always_ff @(posedge i_sys_clk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			sync_a <= '0;
			sync_b <= '0;
		end
		else
		begin
			sync_a <= {i_watchdog_reset_request, i_watchdog_overflow_irq,
				i_nmi_pin, i_external_irq_pins};
			sync_b <= sync_a;
		end
	end

	////////////////////////////////////////////////////////////////
	logic wake;
	ssic_wake_detect #(.N_EXT(N_EXT)) u_wake
	(
		.i_nmi_pin       (sync_b[N_EXT]),
		.i_ext_irq       (sync_b[N_EXT-1:0]),
		.i_ext_irq_en    (i_ext_irq_en),
		.i_periph_irq    (i_periph_irq),
		.i_wdt_irq       (sync_b[N_EXT+1]),
		.i_wdt_rst       (sync_b[N_EXT+2]),
		.i_on_subclock   (i_on_subclock),
		.i_pin_nmi_mask  (i_pin_nonmask_irq_mask),
		.i_wdt_nmi_mask  (i_wdt_nonmask_irq_mask),
		.i_maskable_mask (i_maskable_irq_mask),
		.o_wake          (wake)
	);

	////////////////////////////////////////////////////////////////
	ssic_state_t state;
	logic [31:0] stab_cnt;
	always_ff @(posedge i_sys_clk or negedge rst_s)
	begin
		if (!rst_s)
			state <= SSIC_NORMAL;
		else
		begin
			unique case (state)
				SSIC_NORMAL:
					if (i_stop_request_bit && i_power_save_mode_select)
						state <= SSIC_STOP;
					else if (i_idle_request)
						state <= SSIC_IDLE;
				SSIC_IDLE:
					if (wake)
						state <= SSIC_NORMAL;
				SSIC_STOP:
					if (wake)
						state <= SSIC_STAB;
				SSIC_STAB:
					if (stab_cnt >= STAB_CYC - 1)
						state <= SSIC_NORMAL;
			endcase
		end
	end

	// oscillation stabilisation counter
	always_ff @(posedge i_sys_clk or negedge rst_s)
	begin
		if (!rst_s)
			stab_cnt <= '0;
		else if (state == SSIC_STAB)
			stab_cnt <= stab_cnt + 32'h1;
		else
			stab_cnt <= '0;
	end

	////////////////////////////////////////////////////////////////
	logic [N_CSI-1:0] next_csi_run;
	genvar g;
	generate
		for (g = 0; g < N_CSI; g++)
		begin : g_csi
			always_comb
				next_csi_run[g] = (state == SSIC_NORMAL)
					|| (state == SSIC_IDLE && i_csi_ext_clk_sel[g]);
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			o_main_osc_en       <= 1'b1;
			o_sub_osc_en        <= 1'b1;
			o_cpu_clk_en        <= 1'b1;
			o_periph_clk_en     <= 1'b1;
			o_sub_periph_clk_en <= 1'b1;
			o_ram_hold          <= 1'b0;
			o_port_hold         <= 1'b0;
			o_data_write_block  <= 1'b0;
			o_wdt1_run          <= 1'b1;
			o_wdt2_run          <= 1'b1;
			o_csi_run           <= '1;
			o_uart0_run         <= 1'b1;
			o_other_serial_run  <= 1'b1;
			o_dac_out_en        <= 1'b1;
			o_rto_run           <= 1'b1;
			o_state             <= 2'h0;
		end
		else
		begin
			// oscillator restarts one cycle after stop is left
			o_main_osc_en   <= (state != SSIC_STOP);
			o_sub_osc_en    <= 1'b1;
			// clocks stay gated until stabilised
			o_cpu_clk_en    <= (state == SSIC_NORMAL);
			o_periph_clk_en <= (state == SSIC_NORMAL || state == SSIC_IDLE);
			o_sub_periph_clk_en <= 1'b1;
			o_ram_hold      <= (state != SSIC_NORMAL);
			o_port_hold     <= (state == SSIC_IDLE);
			o_data_write_block <= (state != SSIC_NORMAL);
			o_wdt1_run      <= (state == SSIC_NORMAL);
			o_wdt2_run      <= (state == SSIC_NORMAL)
				|| (state == SSIC_IDLE && i_on_subclock
				&& i_wdt2_subclk_sel);
			o_csi_run       <= next_csi_run;
			o_uart0_run     <= (state == SSIC_NORMAL)
				|| (state == SSIC_IDLE && i_uart0_ext_clk_sel);
			o_other_serial_run <= (state == SSIC_NORMAL);
			o_dac_out_en    <= (state == SSIC_NORMAL
				|| state == SSIC_IDLE);
			o_rto_run       <= (state == SSIC_NORMAL)
				|| (state == SSIC_IDLE && i_rto_timer8_trig
				&& i_timer8_idle_en);
			o_state         <= state;
		end
	end

	////////////////////////////////////////////////////////////////
	a_stop_entry: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state == SSIC_NORMAL && i_stop_request_bit
		&& i_power_save_mode_select) |=> state == SSIC_STOP)
		else $error("stop not entered");
	a_stop_needs_sel: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state != SSIC_STOP) && !i_power_save_mode_select
		|=> state != SSIC_STOP)
		else $error("stop without mode select");
	a_osc_halt: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state == SSIC_STOP) |=> !o_main_osc_en && o_sub_osc_en)
		else $error("main osc not halted");
	a_clk_gate: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state == SSIC_STOP) |=> !o_cpu_clk_en && !o_periph_clk_en)
		else $error("clock not gated in stop");
	a_ram_kept: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state == SSIC_STOP) |=> o_ram_hold && o_sub_periph_clk_en)
		else $error("ram or subclock lost");
	a_masked_nowake: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state == SSIC_STOP && i_maskable_irq_mask && i_pin_nonmask_irq_mask
		&& i_wdt_nonmask_irq_mask && !sync_b[N_EXT+2])
		|=> state == SSIC_STOP)
		else $error("masked request woke");
	a_stab_wait: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		$rose(state == SSIC_STAB) |-> ##1 o_cpu_clk_en == 1'b0 [*2])
		else $error("cpu resumed early");
	a_wdt1_idle: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state == SSIC_IDLE) |=> !o_wdt1_run && o_port_hold)
		else $error("wdt1 runs in idle");
	a_uart_idle: assert property (@(posedge i_sys_clk) disable iff (!rst_s)
		(state == SSIC_IDLE) |=> o_uart0_run == $past(i_uart0_ext_clk_sel)
		&& !o_other_serial_run)
		else $error("uart idle gating wrong");
	c_stop_cycle: cover property (@(posedge i_sys_clk) disable iff (!rst_s)
		state == SSIC_STOP ##1 state == SSIC_STAB);
	c_stab_done: cover property (@(posedge i_sys_clk) disable iff (!rst_s)
		state == SSIC_STAB ##1 state == SSIC_NORMAL);
	c_idle_wake: cover property (@(posedge i_sys_clk) disable iff (!rst_s)
		state == SSIC_IDLE ##1 state == SSIC_NORMAL);
endmodule
`default_nettype wire

// ### ssic_cpu_model.sv
// ssic_cpu_model: software side issuing the standby stores
// assumes: shares the controller clock; stores land 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module ssic_cpu_model
(
	input  wire logic i_clk,        // system clock
	output logic      o_stop_store, // stop bit store pulse
	output logic      o_idle_store, // idle store pulse
	output logic [1:0] o_adc_enable // converter enable pair
);
	initial
	begin
		o_stop_store = 1'b0;
		o_idle_store = 1'b0;
		o_adc_enable = 2'h3;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic store_stop();
		@(posedge i_clk);
		#1 o_stop_store = 1'b1;
		@(posedge i_clk);
		#1 o_stop_store = 1'b0;
		repeat (5) @(posedge i_clk); // nop slots after the store
		#1; // return off the edge so callers never sample launching flops
	endtask
	task automatic store_idle();
		@(posedge i_clk);
		#1 o_adc_enable = 2'h0; // converter off first
		o_idle_store = 1'b1;
		@(posedge i_clk);
		#1 o_idle_store = 1'b0;
		repeat (5) @(posedge i_clk); // nop slots after the store
		#1;
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// tb_top: self-checking bench for the standby controller
// assumes: short stabilisation count; wake pins driven asynchronously
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ssic_pkg::*;
;
	localparam int unsigned STAB = 8;
	logic       clk, rst_b, psm, stp, idl, m_pin, m_wdt, m_mask, nmi;
	logic       pirq, wirq, wrst, onsub, w2sel, u0sel, rtotrig, t8en;
	logic [6:0] ext, ext_en;
	logic [2:0] csisel, csi;
	logic       main_osc, sub_osc, cpu_clk, per_clk, sub_per, ram_hold;
	logic       port_hold, wr_blk, wdt1, wdt2, uart0, oser, dac, rto;
	logic [1:0] state;
	int         error_cnt, cmp_count, n, k;
	always #20 clk = ~clk;
	ssic_cpu_model cpu (.i_clk(clk), .o_stop_store(stp),
		.o_idle_store(idl), .o_adc_enable());
	ssic_top #(.STAB_CYC(STAB)) dut (.i_sys_clk(clk), .i_rst_b(rst_b),
		.i_power_save_mode_select(psm), .i_stop_request_bit(stp),
		.i_idle_request(idl), .i_pin_nonmask_irq_mask(m_pin),
		.i_wdt_nonmask_irq_mask(m_wdt), .i_maskable_irq_mask(m_mask),
		.i_nmi_pin(nmi), .i_external_irq_pins(ext), .i_ext_irq_en(ext_en),
		.i_periph_irq(pirq), .i_watchdog_overflow_irq(wirq),
		.i_watchdog_reset_request(wrst), .i_on_subclock(onsub),
		.i_wdt2_subclk_sel(w2sel), .i_csi_ext_clk_sel(csisel),
		.i_uart0_ext_clk_sel(u0sel), .i_rto_timer8_trig(rtotrig),
		.i_timer8_idle_en(t8en), .o_main_osc_en(main_osc),
		.o_sub_osc_en(sub_osc), .o_cpu_clk_en(cpu_clk),
		.o_periph_clk_en(per_clk), .o_sub_periph_clk_en(sub_per),
		.o_ram_hold(ram_hold), .o_port_hold(port_hold),
		.o_data_write_block(wr_blk), .o_wdt1_run(wdt1), .o_wdt2_run(wdt2),
		.o_csi_run(csi), .o_uart0_run(uart0), .o_other_serial_run(oser),
		.o_dac_out_en(dac), .o_rto_run(rto), .o_state(state));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
		input string msg);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h",
				$time, msg, seen, exp);
		end
	endtask
	// bounded wait for a state, n returns the cycles spent
	task automatic wait_state(input logic [1:0] s, input int lim);
		n = 0;
		while (state !== s && n < lim)
		begin
			@(posedge clk);
			#1 n++;
		end
		check({6'h0, state}, {6'h0, s}, "state");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(40 * 3000);
		error_cnt++;
		final_report();
	end
	initial
	begin
		{clk, rst_b, psm, m_pin, m_wdt, m_mask, nmi, pirq, wirq} = 9'h0;
		{wrst, onsub, w2sel, u0sel, rtotrig, t8en, ext, ext_en} = 20'h0;
		{csisel, error_cnt, cmp_count} = '0;
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		#1 check({main_osc, sub_osc, cpu_clk, per_clk, ram_hold, port_hold,
			state}, 8'hf0, "reset outputs");
		cpu.store_stop();
		check(state, 2'h0, "stop without mode select");
		$display("test refused stop done");
		psm = 1'b1;
		cpu.store_stop();
		check(state, 2'h2, "stop entry");
		check({main_osc, sub_osc, cpu_clk, per_clk, sub_per, ram_hold},
			8'h13, "stop gating");
		cpu.store_idle();
		check(state, 2'h2, "idle store in stop");
		{m_pin, nmi} = 2'h3;
		repeat (8) @(posedge clk);
		#1 check(state, 2'h2, "masked pin wake");
		// pin mask stays set: the synced nmi level lingers two edges
		{m_pin, m_wdt, nmi, m_mask, ext_en, ext} = {4'hd, 7'h7f, 7'h40};
		repeat (8) @(posedge clk);
		#1 check(state, 2'h2, "masked ext wake");
		{m_wdt, m_mask, ext_en, ext, wirq} = 17'h1;
		repeat (8) @(posedge clk);
		#1 check(state, 2'h2, "watchdog wake off subclock");
		{m_wdt, onsub} = 2'h3;
		repeat (8) @(posedge clk);
		#1 check(state, 2'h2, "masked watchdog wake");
		{wirq, onsub, m_wdt, m_pin, nmi} = 5'h1;
		wait_state(2'h3, 10);
		check({main_osc, cpu_clk}, 2'h2, "stabilise gating");
		nmi = 1'b0;
		wait_state(2'h0, STAB + 10);
		check(8'(n), 8'(STAB), "stab time");
		@(posedge clk);
		#1 check(cpu_clk, 1'b1, "cpu clock back");
		$display("test stop entry and release done");
		for (k = 0; k < 4; k++)
		begin
			cpu.store_stop();
			check(state, 2'h2, "stop entry");
			onsub = (k >= 2);
			{ext_en, ext} = (k == 0) ? 14'h81 : 14'h0;
			{pirq, wirq, wrst} = 3'h4 >> (k == 0 ? 3 : k - 1);
			wait_state(2'h3, 10);
			{ext, pirq, wirq, wrst, onsub} = '0;
			wait_state(2'h0, STAB + 10);
		end
		$display("test wake sources done");
		cpu.store_stop();
		check(state, 2'h2, "stop before reset");
		rst_b = 1'b0;
		@(posedge clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		#1 check({main_osc, sub_osc, cpu_clk, per_clk, ram_hold, port_hold,
			state}, 8'hf0, "reset leaves stop");
		$display("test reset in stop done");
		{onsub, w2sel, csisel, u0sel, rtotrig, t8en} = 8'hef;
		cpu.store_idle();
		check(state, 2'h1, "idle entry");
		check({wdt1, wdt2}, 2'h1, "idle watchdogs");
		check({csi, uart0, oser}, 5'h16, "idle serials");
		check({dac, rto}, 2'h3, "idle dac and rto");
		check({port_hold, wr_blk}, 2'h3, "idle holds");
		nmi = 1'b1;
		wait_state(2'h0, 10);
		{nmi, onsub, csisel, u0sel, t8en} = 7'h08;
		cpu.store_idle();
		check({wdt2, rto}, 2'h0, "idle stopped units");
		check({csi, uart0}, 4'h4, "idle serial selects");
		pirq = 1'b1;
		wait_state(2'h0, 10);
		pirq = 1'b0;
		$display("test idle done");
		final_report();
	end
endmodule
`default_nettype wire
